// *** hdl/drf_ctrl.sv ***
// Purpose: refresh scheduler and strobe sequencer driving the memory pins
// Assumes: access engine outside hands the pins over via accReq/accHolding/accGrant
// Notes: strobes active low; no page, nibble or static column modes
`timescale 1ns/10ps
module drf_ctrl #(
    parameter int DIST_PERIOD = drf_pkg::DIST_CYC,
    parameter int INTERVAL = drf_pkg::INTERVAL_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire drf_pkg::drf_method_t method,
    input wire logic burstMode,
    input wire logic enable,
    input wire logic fastModeActive,
    input wire logic accReq,
    input wire logic accHolding,
    output logic accGrant,
    output logic refBusy,
    output logic rowStrobeN,
    output logic colStrobeN,
    output logic [9:0] addr,
    output logic addrOe,
    output logic writeInhibit,
    output logic [8:0] refRow,
    output logic sweepDone,
    output logic overdue
);
    import drf_pkg::*;
    // sequencer states, one-hot
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_CSR = 7'h02,
        S_ACT = 7'h04,
        S_PRE = 7'h08,
        S_HPRE = 7'h10,
        S_GAP = 7'h20,
        S_DONE = 7'h40
    } drf_state_t;
    // all module state
    typedef struct packed {
        drf_state_t st;
        logic [15:0] tmr;
        logic [9:0] burstLeft;
        logic [31:0] ageCnt;
        logic pending;
        logic ras;
        logic cas;
        logic [9:0] addr;
        logic addrOe;
        logic inhib;
        logic overdue;
        drf_method_t m;
    } drf_st_t;
    drf_st_t st_r, st_nxt;
    logic tick;
    logic advance;
    logic [ROW_BITS-1:0] rowCnt;
    logic wrap;
    // distributed spacing enable
    drf_tick_gen #(.PERIOD(DIST_PERIOD)) drf_tick_gen_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(enable),
        .tick(tick)
    );
    // external row counter
    drf_row_ctr #(.ROWS(ROW_COUNT)) drf_row_ctr_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .advance(advance),
        .row(rowCnt),
        .wrap(wrap)
    );
    // sequencer and scheduler
    always_comb begin
        st_nxt = st_r;
        advance = 1'b0;
        // interval watchdog for a whole sweep
        if (wrap) begin
            st_nxt.ageCnt = '0;
        end else if (enable && st_r.ageCnt != 32'hFFFFFFFF) begin
            st_nxt.ageCnt = st_r.ageCnt + 32'h1;
        end
        if (st_r.ageCnt >= 32'(INTERVAL)) begin
            st_nxt.overdue = 1'b1;
        end
        // a new request is held until served; set wins except at a burst start, which drops it
        if (tick) begin
            st_nxt.pending = 1'b1;
        end
        unique case (st_r.st)
            S_IDLE: begin
                // wait for random mode and a free bus
                if ((st_r.pending || tick) && !fastModeActive && !accReq) begin
                    st_nxt.m = method;
                    st_nxt.burstLeft = burstMode ? 10'(ROW_COUNT) : 10'h1;
                    // keep only a tick that lands on a pending start outside burst mode
                    st_nxt.pending = st_r.pending && tick && !burstMode;
                    if (method == DRF_M_HIDDEN && accHolding) begin
                        // end access: row up, column stays low
                        st_nxt.ras = 1'b1;
                        st_nxt.cas = 1'b0;
                        st_nxt.inhib = 1'b1;
                        st_nxt.tmr = 16'(RAS_PRE_CYC - 1);
                        st_nxt.st = S_HPRE;
                    end else if (method == DRF_M_RASONLY) begin
                        st_nxt.addr = {1'b0, rowCnt};
                        st_nxt.addrOe = 1'b1;
                        st_nxt.ras = 1'b0;
                        st_nxt.cas = 1'b1;
                        st_nxt.tmr = 16'(RAS_ACT_CYC - 1);
                        st_nxt.st = S_ACT;
                    end else begin
                        // column first, then row
                        st_nxt.cas = 1'b0;
                        st_nxt.addrOe = 1'b0;
                        st_nxt.tmr = 16'(CSR_CYC - 1);
                        st_nxt.m = DRF_M_CBR;
                        st_nxt.st = S_CSR;
                    end
                end
            end
            S_CSR: begin
                if (st_r.tmr == 16'h0) begin
                    st_nxt.ras = 1'b0;
                    st_nxt.tmr = 16'(RAS_ACT_CYC - 1);
                    st_nxt.st = S_ACT;
                end else begin
                    st_nxt.tmr = st_r.tmr - 16'h1;
                end
            end
            S_HPRE: begin
                // precharge with column still low
                if (st_r.tmr == 16'h0) begin
                    st_nxt.ras = 1'b0;
                    st_nxt.tmr = 16'(RAS_ACT_CYC - 1);
                    st_nxt.st = S_ACT;
                end else begin
                    st_nxt.tmr = st_r.tmr - 16'h1;
                end
            end
            S_ACT: begin
                // column hold is shorter than active time
                if (st_r.m == DRF_M_CBR &&
                    st_r.tmr == 16'(RAS_ACT_CYC - 1 - CHR_CYC)) begin
                    st_nxt.cas = 1'b1;
                end
                if (st_r.tmr == 16'h0) begin
                    st_nxt.ras = 1'b1;
                    st_nxt.tmr = 16'(RAS_PRE_CYC - 1);
                    st_nxt.st = S_PRE;
                end else begin
                    st_nxt.tmr = st_r.tmr - 16'h1;
                end
            end
            S_PRE: begin
                // full cycle: active plus precharge
                if (st_r.tmr == 16'h0) begin
                    advance = (st_r.m == DRF_M_RASONLY);
                    st_nxt.addrOe = 1'b0;
                    st_nxt.burstLeft = st_r.burstLeft - 10'h1;
                    st_nxt.st = (st_r.burstLeft == 10'h1) ? S_DONE : S_GAP;
                end else begin
                    st_nxt.tmr = st_r.tmr - 16'h1;
                end
            end
            S_GAP: begin
                // next burst row back to back
                if (st_r.m == DRF_M_RASONLY) begin
                    st_nxt.addr = {1'b0, rowCnt};
                    st_nxt.addrOe = 1'b1;
                    st_nxt.ras = 1'b0;
                    st_nxt.tmr = 16'(RAS_ACT_CYC - 1);
                    st_nxt.st = S_ACT;
                end else if (st_r.m == DRF_M_CBR) begin
                    st_nxt.cas = 1'b0;
                    st_nxt.tmr = 16'(CSR_CYC - 1);
                    st_nxt.st = S_CSR;
                end else begin
                    // hidden: column still low, re-lower row
                    st_nxt.ras = 1'b0;
                    st_nxt.tmr = 16'(RAS_ACT_CYC - 1);
                    st_nxt.st = S_ACT;
                end
            end
            S_DONE: begin
                // release column and write hold
                st_nxt.cas = 1'b1;
                st_nxt.inhib = 1'b0;
                st_nxt.st = S_IDLE;
            end
            default: begin
                st_nxt.st = S_IDLE;
            end
        endcase
    end
    // register the state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '{st: S_IDLE, tmr: '0, burstLeft: '0, ageCnt: '0,
                      pending: 1'b0, ras: 1'b1, cas: 1'b1, addr: '0,
                      addrOe: 1'b0, inhib: 1'b0, overdue: 1'b0, m: DRF_M_RASONLY};
        end else begin
            st_r <= st_nxt;
        end
    end
    // pin and status outputs
    assign refBusy = (st_r.st != S_IDLE);
    assign accGrant = (st_r.st == S_IDLE) && !st_r.pending;
    assign rowStrobeN = st_r.ras;
    assign colStrobeN = st_r.cas;
    assign addr = st_r.addr;
    assign addrOe = st_r.addrOe;
    assign writeInhibit = st_r.inhib;
    assign refRow = rowCnt;
    assign sweepDone = wrap;
    assign overdue = st_r.overdue;
    // row-only active phase keeps column high
    property p_rasonly_cas_high;
        @(posedge clk) disable iff (sys_rst)
        (st_r.st == S_ACT && st_r.m == DRF_M_RASONLY) |-> colStrobeN;
    endproperty
    a_rasonly_cas_high: assert property (p_rasonly_cas_high) else $error("col low in row-only");
    // row strobe falling edge starts a timed cycle
    sequence s_row_fell;
        $fell(rowStrobeN);
    endsequence
    // seventeen low samples, split to keep each count small
    sequence s_act_hold;
        !rowStrobeN [*8] ##1 !rowStrobeN [*8] ##1 !rowStrobeN;
    endsequence
    // sixteen high samples of precharge
    sequence s_pre_hold;
        rowStrobeN [*8] ##1 rowStrobeN [*8];
    endsequence
    // active phase lasts exactly the active count, then ends
    property p_act_len;
        @(posedge clk) disable iff (sys_rst)
        s_row_fell |-> s_act_hold ##1 rowStrobeN;
    endproperty
    a_act_len: assert property (p_act_len) else $error("row strobe active length wrong");
    // precharge lasts at least the precharge count
    property p_pre_len;
        @(posedge clk) disable iff (sys_rst)
        ($rose(rowStrobeN) && refBusy) |-> s_pre_hold;
    endproperty
    a_pre_len: assert property (p_pre_len) else $error("precharge too short");
    // access grant never overlaps a refresh
    property p_no_grant_busy;
        @(posedge clk) disable iff (sys_rst)
        refBusy |-> !accGrant;
    endproperty
    a_no_grant_busy: assert property (p_no_grant_busy) else $error("grant during refresh");
    // column strobe leads the row strobe
    property p_cbr_order;
        @(posedge clk) disable iff (sys_rst)
        (st_r.st == S_CSR) |-> (!colStrobeN && rowStrobeN);
    endproperty
    a_cbr_order: assert property (p_cbr_order) else $error("column not first");
    // column strobe held after the row strobe falls
    property p_cbr_hold;
        @(posedge clk) disable iff (sys_rst)
        ($fell(rowStrobeN) && st_r.m == DRF_M_CBR) |-> !colStrobeN [*3];
    endproperty
    a_cbr_hold: assert property (p_cbr_hold) else $error("column hold short");
    // hidden precharge keeps column low and writes blocked
    property p_hidden_cas;
        @(posedge clk) disable iff (sys_rst)
        (st_r.st == S_HPRE) |-> (!colStrobeN && rowStrobeN && writeInhibit);
    endproperty
    a_hidden_cas: assert property (p_hidden_cas) else $error("hidden refresh pins wrong");
    // row-only cycle presents the counter row
    property p_row_addr;
        @(posedge clk) disable iff (sys_rst)
        ($fell(rowStrobeN) && st_r.m == DRF_M_RASONLY) |-> (addrOe && addr[8:0] == rowCnt);
    endproperty
    a_row_addr: assert property (p_row_addr) else $error("row address wrong");
    // no refresh start while a fast mode runs
    property p_fast_block;
        @(posedge clk) disable iff (sys_rst)
        (st_r.st == S_IDLE && fastModeActive) |=> (st_r.st == S_IDLE);
    endproperty
    a_fast_block: assert property (p_fast_block) else $error("refresh in fast mode");
endmodule

// *** hdl/drf_pkg.sv ***
// Purpose: shared constants for the row refresh controller
// Assumes: 200 MHz clock, 85 ns speed grade timing
// Notes: pin strobes are active low at the memory
package drf_pkg;
    // clock period in picoseconds
    localparam int CLK_PERIOD_PS = 5000;
    // refresh interval and row count
    localparam int REFRESH_INTERVAL_US = 8000;
    localparam int ROW_COUNT = 512;
    localparam int ROW_BITS = 9;
    // cells restored per refresh cycle
    localparam int CELLS_PER_ROW = 2048;
    // distributed spacing, microseconds
    localparam int DIST_SPACING_US = 15;
    // timing in nanoseconds
    localparam int RANDOM_CYCLE_TIME_NS = 165;
    localparam int ROW_STROBE_ACTIVE_TIME_NS = 85;
    localparam int ROW_STROBE_PRECHARGE_TIME_NS = 80;
    localparam int COLSTROBE_SETUP_BEFORE_ROWSTROBE_NS = 10;
    localparam int COLSTROBE_HOLD_AFTER_ROWSTROBE_NS = 15;
    // least times round up
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction
    // longest time rounds down
    function automatic int us2cycDn(input int us);
        int c;
        // widen first: the full interval overflows a 32-bit product
        c = int'((longint'(us) * 1000000) / CLK_PERIOD_PS);
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RAS_ACT_CYC = ns2cyc(ROW_STROBE_ACTIVE_TIME_NS);
    localparam int RAS_PRE_CYC = ns2cyc(ROW_STROBE_PRECHARGE_TIME_NS);
    localparam int CSR_CYC = ns2cyc(COLSTROBE_SETUP_BEFORE_ROWSTROBE_NS);
    localparam int CHR_CYC = ns2cyc(COLSTROBE_HOLD_AFTER_ROWSTROBE_NS);
    localparam int CYCLE_CYC = ns2cyc(RANDOM_CYCLE_TIME_NS);
    localparam int DIST_CYC = us2cycDn(DIST_SPACING_US);
    localparam int INTERVAL_CYC = us2cycDn(REFRESH_INTERVAL_US);
    // refresh methods
    typedef enum logic [1:0] {
        DRF_M_RASONLY = 2'h0,
        DRF_M_CBR = 2'h1,
        DRF_M_HIDDEN = 2'h2
    } drf_method_t;
endpackage

// *** hdl/drf_tick_gen.sv ***
// Purpose: periodic one-cycle enable for distributed refresh spacing
// Assumes: single clock, synchronous active-high reset
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/10ps
module drf_tick_gen #(
    parameter int PERIOD = 3000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    output logic tick
);
    import drf_pkg::*;
    // state of the divider
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } drf_tick_st_t;
    drf_tick_st_t st_r, st_nxt;
    // count down, pulse on wrap
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!enable) begin
            st_nxt.cnt = 32'(PERIOD - 1);
        end else if (st_r.cnt == 32'h0) begin
            st_nxt.cnt = 32'(PERIOD - 1);
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt - 32'h1;
        end
    end
    // register the state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign tick = st_r.tick;
endmodule

// *** hdl/drf_row_ctr.sv ***
// Purpose: external refresh row counter for row-strobe-only refresh
// Assumes: advanced once per completed row-only refresh cycle
// Notes: wraps modulo the row count
`timescale 1ns/10ps
module drf_row_ctr #(
    parameter int ROWS = 512
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic advance,
    output logic [drf_pkg::ROW_BITS-1:0] row,
    output logic wrap
);
    import drf_pkg::*;
    // counter state
    typedef struct packed {
        logic [ROW_BITS-1:0] row;
        logic wrap;
    } drf_ctr_st_t;
    drf_ctr_st_t st_r, st_nxt;
    // step and wrap
    always_comb begin
        st_nxt = st_r;
        st_nxt.wrap = 1'b0;
        if (advance) begin
            if (st_r.row == ROW_BITS'(ROWS - 1)) begin
                st_nxt.row = '0;
                st_nxt.wrap = 1'b1;
            end else begin
                st_nxt.row = st_r.row + ROW_BITS'(1);
            end
        end
    end
    // register the state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign row = st_r.row;
    assign wrap = st_r.wrap;
endmodule

// *** test/drf_dram_model.sv ***
// Purpose: behavioural memory that answers the refresh strobes
// Assumes: strobes active low, driven by the controller only
// Notes: counts refreshes, flags bad row-only addressing
`timescale 1ns/10ps
module drf_dram_model #(
    parameter int CELLS = 2048
) (
    input wire logic rowStrobeN,
    input wire logic colStrobeN,
    input wire logic [9:0] addr,
    input wire logic addrOe,
    output logic dq,
    output int rowOnlyCount,
    output int cbrCount,
    output int seqErr
);
    logic [8:0] internCtr = 9'h0; // own row counter, stepped by each column-first refresh
    logic [8:0] lastRow = 9'h0; // last externally named row
    logic [8:0] rowLatched = 9'h0; // row opened by the current cycle
    logic first = 1'b1; // no row-only refresh seen yet
    logic heldBit = 1'b0; // data shown while column strobe low
    logic flip = 1'b0; // keeps a released output moving
    int cellsRestored = 0; // whole row across both halves
    initial begin
        rowOnlyCount = 0;
        cbrCount = 0;
        seqErr = 0;
    end
    // row strobe falling opens a row: order of strobes picks its source
    always @(negedge rowStrobeN) begin
        // let the address settle from the same clock edge
        #1;
        if (colStrobeN === 1'b1) begin
            rowLatched = addr[8:0];
            if (addrOe !== 1'b1) seqErr++;
            if (!first && addr[8:0] !== 9'(lastRow + 9'h1)) seqErr++;
            first = 1'b0;
            lastRow = addr[8:0];
            rowOnlyCount++;
        end else begin
            rowLatched = internCtr;
            internCtr = internCtr + 9'h1;
            cbrCount++;
        end
        cellsRestored = cellsRestored + CELLS;
    end
    // output held while column strobe low, even over refresh cycles
    always @(negedge colStrobeN) heldBit = rowLatched[0];
    always @(rowStrobeN) flip = ~flip;
    assign dq = colStrobeN ? (~heldBit ^ flip) : heldBit;
endmodule

// *** test/dram_row_refresh_protocol_bench.sv ***
// Purpose: self-checking bench for the refresh controller
// Assumes: shortened tick spacing and age limit
// Notes: bench plays the access engine
`timescale 1ns/10ps
module dram_row_refresh_protocol_bench;
    import drf_pkg::*;
    localparam int DIST = 50; // short spacing tick
    localparam int INTV = 30000; // short age limit
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    drf_method_t method = DRF_M_RASONLY;
    logic burstMode = 1'b0;
    logic enable = 1'b0;
    logic fastModeActive = 1'b0;
    logic accReq = 1'b0;
    logic accHolding = 1'b0;
    logic accGrant, refBusy, rowStrobeN, colStrobeN, addrOe;
    logic writeInhibit, sweepDone, overdue, dq;
    logic [9:0] addr;
    logic [8:0] refRow;
    int rowOnlyCount, cbrCount, seqErr;
    int fails = 0;
    int comparisons = 0;
    drf_ctrl #(.DIST_PERIOD(DIST), .INTERVAL(INTV)) drf_ctrl_inst (
        .clk(clk), .sys_rst(sysRst), .method(method), .burstMode(burstMode),
        .enable(enable), .fastModeActive(fastModeActive), .accReq(accReq),
        .accHolding(accHolding), .accGrant(accGrant), .refBusy(refBusy),
        .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .addr(addr),
        .addrOe(addrOe), .writeInhibit(writeInhibit), .refRow(refRow),
        .sweepDone(sweepDone), .overdue(overdue));
    drf_dram_model drf_dram_model_inst (
        .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .addr(addr),
        .addrOe(addrOe), .dq(dq), .rowOnlyCount(rowOnlyCount),
        .cbrCount(cbrCount), .seqErr(seqErr));
    // free-running clock
    always #2.5 clk = ~clk;
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic waitBusy(input int bound);
        int i;
        i = 0;
        while (refBusy !== 1'b1 && i < bound) begin
            step(1);
            i++;
        end
        cmp("refresh started", 32'h1, {31'h0, refBusy});
    endtask
    task automatic waitIdle();
        int i;
        i = 0;
        while (refBusy !== 1'b0 && i < 100) begin
            step(1);
            i++;
        end
    endtask
    // row-only cycle: timing, address, counter step
    task automatic rowOnlyCycle();
        int lo, hi;
        logic colBad;
        logic [8:0] row0;
        lo = 0;
        hi = 0;
        colBad = 1'b0;
        waitIdle();
        row0 = refRow;
        method = DRF_M_RASONLY;
        waitBusy(DIST + 40);
        while (rowStrobeN !== 1'b0 && lo < 5) begin
            step(1);
            lo++;
        end
        lo = 0;
        cmp("row address", {23'h0, row0}, {22'h0, addr});
        cmp("address driven", 32'h1, {31'h0, addrOe});
        while (rowStrobeN === 1'b0 && lo < 100) begin
            if (colStrobeN !== 1'b1) colBad = 1'b1;
            step(1);
            lo++;
        end
        while (refBusy === 1'b1 && hi < 100) begin
            if (colStrobeN !== 1'b1) colBad = 1'b1;
            step(1);
            hi++;
        end
        cmp("row low cycles", RAS_ACT_CYC, lo);
        cmp("cycle span", 32'h1, {31'h0, (lo + hi) >= CYCLE_CYC});
        cmp("column high", 32'h0, {31'h0, colBad});
        cmp("row advance", {23'h0, 9'(row0 + 9'h1)}, {23'h0, refRow});
    endtask
    // column-before-row: lead and hold of the column strobe
    task automatic cbrCycle();
        int lead, hold, i, c0;
        lead = 0;
        hold = 0;
        i = 0;
        waitIdle();
        method = DRF_M_CBR;
        c0 = cbrCount;
        waitBusy(DIST + 40);
        while (rowStrobeN !== 1'b0 && i < 20) begin
            if (colStrobeN === 1'b0) lead++;
            step(1);
            i++;
        end
        while (colStrobeN === 1'b0 && hold < 20) begin
            step(1);
            hold++;
        end
        cmp("column lead", CSR_CYC, lead);
        cmp("column hold", 32'h1, {31'h0, hold >= CHR_CYC});
        waitIdle();
        cmp("internal refresh", c0 + 1, cbrCount);
    endtask
    // a held access or a fast mode keeps refresh off
    task automatic defer(input logic useFast);
        waitIdle();
        method = DRF_M_RASONLY;
        if (useFast) fastModeActive = 1'b1;
        else accReq = 1'b1;
        step(2 * DIST);
        cmp("refresh held off", 32'h0, {31'h0, refBusy});
        cmp("grant withheld", 32'h0, {31'h0, accGrant});
        fastModeActive = 1'b0;
        accReq = 1'b0;
        waitBusy(5);
    endtask
    // hidden refresh behind a held access
    task automatic hiddenCycle();
        int i, c0;
        logic bad, prevRow;
        i = 0;
        bad = 1'b0;
        waitIdle();
        c0 = cbrCount;
        method = DRF_M_HIDDEN;
        accHolding = 1'b1;
        waitBusy(DIST + 40);
        prevRow = rowStrobeN;
        while (refBusy === 1'b1 && i < 200) begin
            if (rowStrobeN === 1'b0 && writeInhibit !== 1'b1) bad = 1'b1;
            if (prevRow === 1'b1 && rowStrobeN === 1'b0 && colStrobeN !== 1'b0) bad = 1'b1;
            prevRow = rowStrobeN;
            step(1);
            i++;
        end
        accHolding = 1'b0;
        cmp("hidden strobes and inhibit", 32'h0, {31'h0, bad});
        cmp("hidden refresh", c0 + 1, cbrCount);
    endtask
    // burst: whole sweep back to back, grant low, one wrap
    task automatic burstRun();
        int i, r0;
        logic wrap, bad;
        i = 0;
        wrap = 1'b0;
        bad = 1'b0;
        waitIdle();
        method = DRF_M_RASONLY;
        r0 = rowOnlyCount;
        burstMode = 1'b1;
        while (rowOnlyCount - r0 < ROW_COUNT && i < 25000) begin
            if (sweepDone === 1'b1) wrap = 1'b1;
            if (refBusy === 1'b1 && accGrant !== 1'b0) bad = 1'b1;
            // once rows flow, busy must not drop before the sweep ends
            if (rowOnlyCount != r0 && refBusy !== 1'b1) bad = 1'b1;
            step(1);
            i++;
        end
        burstMode = 1'b0;
        repeat (40) begin
            if (sweepDone === 1'b1) wrap = 1'b1;
            step(1);
        end
        cmp("burst rows", 32'h1, {31'h0, rowOnlyCount - r0 >= ROW_COUNT});
        cmp("burst length", 32'h1, {31'h0, i <= DIST + ROW_COUNT * 40});
        cmp("sweep pulse", 32'h1, {31'h0, wrap});
        cmp("grant in burst", 32'h0, {31'h0, bad});
        cmp("row order", 32'h0, seqErr);
    endtask
    // no wrap within the age limit raises the sticky flag
    task automatic overdueRun();
        method = DRF_M_CBR;
        cmp("not overdue", 32'h0, {31'h0, overdue});
        step(INTV + 100);
        cmp("overdue", 32'h1, {31'h0, overdue});
    endtask
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        sysRst = 1'b0;
        cmp("row strobe idle", 32'h1, {31'h0, rowStrobeN});
        cmp("column strobe idle", 32'h1, {31'h0, colStrobeN});
        cmp("address released", 32'h0, {31'h0, addrOe});
        cmp("grant after reset", 32'h1, {31'h0, accGrant});
        enable = 1'b1;
        rowOnlyCycle();
        rowOnlyCycle();
        cbrCycle();
        defer(1'b0);
        defer(1'b1);
        hiddenCycle();
        burstRun();
        overdueRun();
        summarize();
    end
    // watchdog against a hang
    initial begin
        // about 48k cycles expected; allow 80k
        #400000;
        fails++;
        summarize();
    end
endmodule
